// ---- rtl/tpc_pkg.sv ----
/*
 * Package for the transmit path control register bank: register indexes,
 * writable masks, field positions, reset values, decoded lengths and the
 * bus phase states.
 * Assumes one bus clock and four framer ports sharing one register map.
 */
package tpc_pkg;

  // ----------------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------------
  localparam int         NPORT      = 4;
  localparam int         ADDR_LSB   = 2;      // byte address = 4 x index
  localparam int         LOC_W      = 9;      // index bits within one port
  localparam int         PORT_W     = 2;      // port field above the local index
  localparam int         IDX_TOP    = ADDR_LSB + LOC_W + PORT_W;

  // ----------------------------------------------------------------------
  // register indexes within one port (port n adds 200h x (n - 1))
  // ----------------------------------------------------------------------
  localparam logic [8:0] IDX_ALARM  = 9'h186;
  localparam logic [8:0] IDX_WMARK  = 9'h187;
  localparam logic [8:0] IDX_IBO    = 9'h188;
  localparam logic [8:0] IDX_MONSEL = 9'h189;
  localparam logic [8:0] IDX_XPC    = 9'h18A;
  localparam logic [8:0] IDX_TPBS   = 9'h18B;
  localparam logic [8:0] IDX_MODE   = 9'h18C;
  localparam logic [8:0] IDX_LCBS   = 9'h18D;
  localparam logic [8:0] IDX_SYNC   = 9'h18E;
  localparam logic [8:0] IDX_MONVAL = 9'h18F;
  localparam logic [8:0] IDX_CHS_A  = 9'h1DC;
  localparam logic [8:0] IDX_CHS_B  = 9'h1DD;
  localparam logic [8:0] IDX_CHS_C  = 9'h1DE;
  localparam logic [8:0] IDX_CHS_D  = 9'h1DF;

  // ----------------------------------------------------------------------
  // writable bits and reset value
  // ----------------------------------------------------------------------
  localparam logic [7:0] MSK_ALARM  = 8'h07;
  localparam logic [7:0] MSK_WMARK  = 8'h03;
  localparam logic [7:0] MSK_IBO    = 8'h18;
  localparam logic [7:0] MSK_MONSEL = 8'h1F;
  localparam logic [7:0] MSK_XPC    = 8'hC7;
  localparam logic [7:0] MSK_MODE   = 8'h03;
  localparam logic [7:0] MSK_SYNC   = 8'h0F;
  localparam logic [7:0] MSK_FULL   = 8'hFF;
  localparam logic [7:0] RST_REG    = 8'h00;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int ALARM_MODE_BIT = 2;
  localparam int IBO_KIND_BIT   = 4;
  localparam int IBO_EN_BIT     = 3;
  localparam int XPC_MAP_BIT    = 7;
  localparam int XPC_LCEN_BIT   = 6;
  localparam int XPC_DIR_BIT    = 2;
  localparam int XPC_FILL_BIT   = 1;
  localparam int XPC_TPEN_BIT   = 0;
  localparam int SYNC_CRC_BIT   = 3;
  localparam int SYNC_EN_BIT    = 2;
  localparam int SYNC_AUTO_BIT  = 1;
  localparam int SYNC_RSY_BIT   = 0;
  localparam int MODE_E1_BIT    = 0;
  localparam int MODE_AIS_BIT   = 1;

  // ----------------------------------------------------------------------
  // decoded lengths
  // ----------------------------------------------------------------------
  localparam logic [4:0] LOOP_LONG_00  = 5'h05;
  localparam logic [4:0] LOOP_LONG_01  = 5'h06;
  localparam logic [4:0] LOOP_LONG_10  = 5'h07;
  localparam logic [4:0] LOOP_LONG_11  = 5'h10;
  localparam logic [4:0] LOOP_SHORT_01 = 5'h03;
  localparam logic [4:0] LOOP_SHORT_11 = 5'h01;
  localparam logic [5:0] WMARK_00      = 6'h04;
  localparam logic [5:0] WMARK_01      = 6'h10;
  localparam logic [5:0] WMARK_10      = 6'h20;
  localparam logic [5:0] WMARK_11      = 6'h30;

  // ----------------------------------------------------------------------
  // bus phase states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE    = 2'b00,
    BUS_WRITE   = 2'b01,
    BUS_RD_WAIT = 2'b10,
    BUS_RD_DONE = 2'b11
  } tpc_bus_t;

endpackage

// ---- rtl/tpc_tx_path_regs.sv ----
/*
 * Transmit path control register bank for four framer ports, reached over
 * an AHB-Lite slave, with the decoded settings driven to the line logic.
 * Assumes the line logic runs on hclk and reports the channel it is in.
 */
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps

// Behaviour
// [R01] T1 alarm send: mode 0 plain all-ones, mode 1 customer-installation pattern.
// [R02] T1 loop code field: 00=5, 01=6/3, 10=7, 11=16..1 bits.
// [R03] small FIFO low mark codes 00..11 give 4, 16, 32, 48 bytes.
// [R04] interleave kind: 0 channel interleave, 1 frame interleave.
// [R05] interleave enable: 0 off, 1 backplane interleave on.
// [R06] five-bit monitor select, code 0 is channel 1, 11111 is 32.
// [R07] T1: mapping 0 onto timeslots, 1 onto facility data link bits.
// [R08] E1: mapping 0 onto timeslots, 1 onto Sa spare bits.
// [R09] large controller enable: 0 inactive, 1 active.
// [R10] test port direction: 0 into transmit path, 1 into receive output.
// [R11] T1 test port: 0 skips framing bit, 1 also fills it.
// [R12] test port enable: 0 inactive, 1 active.
// [R13] test port suppress bit k excludes channel bit k+1.
// [R14] 32 channel picks enable controller clock and data per channel time.
// [R15] large suppress bits stop channel bits; Sa mode bits 4..0 are Sa4..Sa8.
// [R16] E1 synchronizer seeks CRC-4 multiframe word only when enabled.
// [R17] synchronizer enable: 0 disabled, 1 enabled.
// [R18] each port owns a copy at base plus 200h times port minus one.
// [R19] rising edge of resync bit starts one transmit resynchronization.
// [R20] auto resync: 0 allowed, 1 disabled.
// [R21] reserved bits ignore writes and read zero.
module tpc_tx_path_regs
  import tpc_pkg::*;
(
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  input  wire logic [NPORT-1:0]       line_chan_valid,
  input  wire logic [NPORT*5-1:0]     line_chan_num,
  input  wire logic [NPORT*8-1:0]     line_chan_data,
  output logic [NPORT-1:0]            ais_all_ones,
  output logic [NPORT-1:0]            ais_ci_pattern,
  output logic [NPORT*5-1:0]          loop_len_long,
  output logic [NPORT*5-1:0]          loop_len_short,
  output logic [NPORT*6-1:0]          small_fifo_low_mark,
  output logic [NPORT-1:0]            interleave_on,
  output logic [NPORT-1:0]            interleave_frame,
  output logic [NPORT-1:0]            large_ctrl_active,
  output logic [NPORT-1:0]            large_ctrl_on_fdl,
  output logic [NPORT-1:0]            large_ctrl_on_sa,
  output logic [NPORT-1:0]            large_ctrl_slot_en,
  output logic [NPORT*8-1:0]          large_ctrl_bit_use,
  output logic [NPORT*5-1:0]          large_ctrl_sa_use,
  output logic [NPORT-1:0]            test_port_to_tx,
  output logic [NPORT-1:0]            test_port_to_rx,
  output logic [NPORT-1:0]            test_port_fbit_fill,
  output logic [NPORT*8-1:0]          test_port_bit_use,
  output logic [NPORT-1:0]            sync_enable,
  output logic [NPORT-1:0]            crc_multiframe_search,
  output logic [NPORT-1:0]            auto_resync_allowed,
  output logic [NPORT-1:0]            resync_start
);

  // ----------------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------------
  tpc_bus_t                bus_st_ff;
  tpc_bus_t                nxt_bus_st;
  logic [31:0]             addr_ff;
  logic                    size_ok_ff;
  logic [7:0]              rdata_ff;
  logic [7:0]              nxt_rdata;
  logic                    acc;
  logic                    addr_ok;
  logic                    wr_en;
  logic [PORT_W-1:0]       sel_port;
  logic [LOC_W-1:0]        sel_loc;

  logic [7:0]              alarm_ff  [NPORT];
  logic [7:0]              wmark_ff  [NPORT];
  logic [7:0]              ibo_ff    [NPORT];
  logic [7:0]              monsel_ff [NPORT];
  logic [7:0]              xpc_ff    [NPORT];
  logic [7:0]              tpbs_ff   [NPORT];
  logic [7:0]              mode_ff   [NPORT];
  logic [7:0]              lcbs_ff   [NPORT];
  logic [7:0]              sync_ff   [NPORT];
  logic [7:0]              monval_ff [NPORT];
  logic [31:0]             chs_ff    [NPORT];

  assign acc       = hsel & htrans[1] & hready;
  assign hresp     = 1'b0;
  assign hreadyout = (bus_st_ff != BUS_RD_WAIT);   // reads take one wait state
  assign hrdata    = {24'h000000, rdata_ff};
  assign sel_port  = addr_ff[IDX_TOP-1 -: PORT_W];
  assign sel_loc   = addr_ff[ADDR_LSB +: LOC_W];
  // anything above the four port windows, misaligned or not a word is unmapped
  assign addr_ok   = size_ok_ff & (addr_ff[31:IDX_TOP] == '0) & (addr_ff[1:0] == 2'h0);
  assign wr_en     = (bus_st_ff == BUS_WRITE) & addr_ok;

  // phase sequencing
  always_comb begin
    case (bus_st_ff)
      BUS_RD_WAIT: nxt_bus_st = BUS_RD_DONE;
      BUS_IDLE, BUS_WRITE, BUS_RD_DONE: begin
        if (acc) begin
          nxt_bus_st = hwrite ? BUS_WRITE : BUS_RD_WAIT;
        end else begin
          nxt_bus_st = BUS_IDLE;
        end
      end
      default: nxt_bus_st = BUS_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_st_ff <= BUS_IDLE;
    end else begin
      bus_st_ff <= nxt_bus_st;
    end
  end

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_ff    <= 32'h00000000;
      size_ok_ff <= 1'b0;
    end else if (acc) begin
      addr_ff    <= haddr;
      size_ok_ff <= (hsize == 3'h2);
    end
  end

  // read mux; unmapped and reserved positions return zero
  always_comb begin
    nxt_rdata = 8'h00;
    if (addr_ok) begin
      case (sel_loc)
        IDX_ALARM:  nxt_rdata = alarm_ff[sel_port];
        IDX_WMARK:  nxt_rdata = wmark_ff[sel_port];
        IDX_IBO:    nxt_rdata = ibo_ff[sel_port];
        IDX_MONSEL: nxt_rdata = monsel_ff[sel_port];
        IDX_XPC:    nxt_rdata = xpc_ff[sel_port];
        IDX_TPBS:   nxt_rdata = tpbs_ff[sel_port];
        IDX_MODE:   nxt_rdata = mode_ff[sel_port];
        IDX_LCBS:   nxt_rdata = lcbs_ff[sel_port];
        IDX_SYNC:   nxt_rdata = sync_ff[sel_port];
        IDX_MONVAL: nxt_rdata = monval_ff[sel_port];
        IDX_CHS_A:  nxt_rdata = chs_ff[sel_port][7:0];
        IDX_CHS_B:  nxt_rdata = chs_ff[sel_port][15:8];
        IDX_CHS_C:  nxt_rdata = chs_ff[sel_port][23:16];
        IDX_CHS_D:  nxt_rdata = chs_ff[sel_port][31:24];
        default:    nxt_rdata = 8'h00;  // R21
      endcase
    end
  end

  // read data is sampled in the wait state so it never races a write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_ff <= 8'h00;
    end else if (bus_st_ff == BUS_RD_WAIT) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // per-port registers and decoded settings
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NPORT; g++) begin : gen_port
      logic       wr_here;
      logic [4:0] cnum;
      logic       is_e1;

      assign wr_here = wr_en & (sel_port == PORT_W'(g)); // R18
      assign cnum    = line_chan_num[g*5 +: 5];
      assign is_e1   = mode_ff[g][MODE_E1_BIT];

      // software writes; only documented bits are kept
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          alarm_ff[g]  <= RST_REG;
          wmark_ff[g]  <= RST_REG;
          ibo_ff[g]    <= RST_REG;
          monsel_ff[g] <= RST_REG;
          xpc_ff[g]    <= RST_REG;
          tpbs_ff[g]   <= RST_REG;
          mode_ff[g]   <= RST_REG;
          lcbs_ff[g]   <= RST_REG;
          sync_ff[g]   <= RST_REG;
          chs_ff[g]    <= {4{RST_REG}};
        end else if (wr_here) begin
          case (sel_loc)
            IDX_ALARM:  alarm_ff[g]         <= hwdata[7:0] & MSK_ALARM;  // R21
            IDX_WMARK:  wmark_ff[g]         <= hwdata[7:0] & MSK_WMARK;  // R21
            IDX_IBO:    ibo_ff[g]           <= hwdata[7:0] & MSK_IBO;    // R21
            IDX_MONSEL: monsel_ff[g]        <= hwdata[7:0] & MSK_MONSEL; // R21
            IDX_XPC:    xpc_ff[g]           <= hwdata[7:0] & MSK_XPC;    // R21
            IDX_TPBS:   tpbs_ff[g]          <= hwdata[7:0] & MSK_FULL;
            IDX_MODE:   mode_ff[g]          <= hwdata[7:0] & MSK_MODE;   // R21
            IDX_LCBS:   lcbs_ff[g]          <= hwdata[7:0] & MSK_FULL;
            IDX_SYNC:   sync_ff[g]          <= hwdata[7:0] & MSK_SYNC;   // R21
            IDX_CHS_A:  chs_ff[g][7:0]      <= hwdata[7:0];
            IDX_CHS_B:  chs_ff[g][15:8]     <= hwdata[7:0];
            IDX_CHS_C:  chs_ff[g][23:16]    <= hwdata[7:0];
            IDX_CHS_D:  chs_ff[g][31:24]    <= hwdata[7:0];
            default:    chs_ff[g]           <= chs_ff[g];
          endcase
        end
      end

      // resync fires on a written 0-to-1 of the bit, never on a held 1
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          resync_start[g] <= 1'b0;
        end else begin
          resync_start[g] <= wr_here & (sel_loc == IDX_SYNC) & hwdata[SYNC_RSY_BIT]
                             & ~sync_ff[g][SYNC_RSY_BIT]; // R19
        end
      end

      // channel monitor: code 0 is channel 1, so code equals line slot index
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          monval_ff[g] <= RST_REG;
        end else if (line_chan_valid[g] && cnum == monsel_ff[g][4:0]) begin
          monval_ff[g] <= line_chan_data[g*8 +: 8]; // R06
        end
      end

      // decoded settings, registered toward the line logic
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ais_all_ones[g]            <= 1'b0;
          ais_ci_pattern[g]          <= 1'b0;
          loop_len_long[g*5 +: 5]    <= LOOP_LONG_00;
          loop_len_short[g*5 +: 5]   <= LOOP_LONG_00;
          small_fifo_low_mark[g*6 +: 6] <= WMARK_00;
          interleave_on[g]           <= 1'b0;
          interleave_frame[g]        <= 1'b0;
          large_ctrl_active[g]       <= 1'b0;
          large_ctrl_on_fdl[g]       <= 1'b0;
          large_ctrl_on_sa[g]        <= 1'b0;
          large_ctrl_slot_en[g]      <= 1'b0;
          large_ctrl_bit_use[g*8 +: 8] <= 8'hFF;
          large_ctrl_sa_use[g*5 +: 5]  <= 5'h1F;
          test_port_to_tx[g]         <= 1'b0;
          test_port_to_rx[g]         <= 1'b0;
          test_port_fbit_fill[g]     <= 1'b0;
          test_port_bit_use[g*8 +: 8]  <= 8'hFF;
          sync_enable[g]             <= 1'b0;
          crc_multiframe_search[g]   <= 1'b0;
          auto_resync_allowed[g]     <= 1'b1;
        end else begin
          ais_all_ones[g]   <= ~is_e1 & mode_ff[g][MODE_AIS_BIT]
                               & ~alarm_ff[g][ALARM_MODE_BIT]; // R01
          ais_ci_pattern[g] <= ~is_e1 & mode_ff[g][MODE_AIS_BIT]
                               & alarm_ff[g][ALARM_MODE_BIT];  // R01
          case (alarm_ff[g][1:0])
            2'h0: begin
              loop_len_long[g*5 +: 5]  <= LOOP_LONG_00;  // R02
              loop_len_short[g*5 +: 5] <= LOOP_LONG_00;
            end
            2'h1: begin
              loop_len_long[g*5 +: 5]  <= LOOP_LONG_01;  // R02
              loop_len_short[g*5 +: 5] <= LOOP_SHORT_01;
            end
            2'h2: begin
              loop_len_long[g*5 +: 5]  <= LOOP_LONG_10;  // R02
              loop_len_short[g*5 +: 5] <= LOOP_LONG_10;
            end
            default: begin
              loop_len_long[g*5 +: 5]  <= LOOP_LONG_11;  // R02
              loop_len_short[g*5 +: 5] <= LOOP_SHORT_11;
            end
          endcase
          case (wmark_ff[g][1:0])
            2'h0:    small_fifo_low_mark[g*6 +: 6] <= WMARK_00; // R03
            2'h1:    small_fifo_low_mark[g*6 +: 6] <= WMARK_01; // R03
            2'h2:    small_fifo_low_mark[g*6 +: 6] <= WMARK_10; // R03
            default: small_fifo_low_mark[g*6 +: 6] <= WMARK_11; // R03
          endcase
          interleave_on[g]      <= ibo_ff[g][IBO_EN_BIT];   // R05
          interleave_frame[g]   <= ibo_ff[g][IBO_KIND_BIT]; // R04
          large_ctrl_active[g]  <= xpc_ff[g][XPC_LCEN_BIT]; // R09
          large_ctrl_on_fdl[g]  <= xpc_ff[g][XPC_LCEN_BIT] & xpc_ff[g][XPC_MAP_BIT]
                                   & ~is_e1; // R07
          large_ctrl_on_sa[g]   <= xpc_ff[g][XPC_LCEN_BIT] & xpc_ff[g][XPC_MAP_BIT]
                                   & is_e1;  // R08
          // clock gate for the controller during each picked channel time
          large_ctrl_slot_en[g] <= xpc_ff[g][XPC_LCEN_BIT] & ~xpc_ff[g][XPC_MAP_BIT]
                                   & line_chan_valid[g] & chs_ff[g][cnum]; // R14
          large_ctrl_bit_use[g*8 +: 8] <= ~lcbs_ff[g]; // R15
          // Sa4 sits in bit 0 of the output, taken from suppress bit 4
          large_ctrl_sa_use[g*5 +: 5]  <= ~{lcbs_ff[g][0], lcbs_ff[g][1], lcbs_ff[g][2],
                                            lcbs_ff[g][3], lcbs_ff[g][4]}; // R15
          test_port_to_tx[g]     <= xpc_ff[g][XPC_TPEN_BIT] & ~xpc_ff[g][XPC_DIR_BIT]; // R10 R12
          test_port_to_rx[g]     <= xpc_ff[g][XPC_TPEN_BIT] & xpc_ff[g][XPC_DIR_BIT];  // R10 R12
          test_port_fbit_fill[g] <= xpc_ff[g][XPC_TPEN_BIT] & xpc_ff[g][XPC_FILL_BIT]
                                    & ~is_e1; // R11
          test_port_bit_use[g*8 +: 8] <= ~tpbs_ff[g]; // R13
          sync_enable[g]           <= sync_ff[g][SYNC_EN_BIT]; // R17
          crc_multiframe_search[g] <= sync_ff[g][SYNC_EN_BIT] & sync_ff[g][SYNC_CRC_BIT]
                                      & is_e1; // R16
          auto_resync_allowed[g]   <= ~sync_ff[g][SYNC_AUTO_BIT]; // R20
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // assertions on port 0 and on the bus read wait state
  // ----------------------------------------------------------------------
  logic wr_sync0;
  logic wr_wm0;
  logic hit0;
  assign wr_sync0 = wr_en & (sel_port == 2'h0) & (sel_loc == IDX_SYNC);
  assign wr_wm0   = wr_en & (sel_port == 2'h0) & (sel_loc == IDX_WMARK);
  assign hit0     = line_chan_valid[0] & chs_ff[0][line_chan_num[4:0]];

  property p_resync_edge;
    @(posedge hclk) disable iff (!hresetn)
    resync_start[0] |-> $past(wr_sync0) && !$past(sync_ff[0][SYNC_RSY_BIT]);
  endproperty
  a_resync_edge: assert property (p_resync_edge) // R19
    else $error("resync pulse without a written rising edge");

  property p_resync_one;
    @(posedge hclk) disable iff (!hresetn)
    (wr_sync0 && hwdata[0] && sync_ff[0][0]) |=> !resync_start[0];
  endproperty
  a_resync_one: assert property (p_resync_one) // R19
    else $error("resync repeated while bit held high");

  property p_wmark_48;
    @(posedge hclk) disable iff (!hresetn)
    (wr_wm0 && hwdata[1:0] == 2'h3) |-> ##2 small_fifo_low_mark[5:0] == 6'h30;
  endproperty
  a_wmark_48: assert property (p_wmark_48) // R03
    else $error("low mark not 48 bytes after code 11");

  property p_reserved_zero;
    @(posedge hclk) disable iff (!hresetn)
    (wr_wm0 && hwdata[7:2] != 6'h00) |=> wmark_ff[0][7:2] == 6'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // R21
    else $error("reserved bits kept a written value");

  property p_monitor;
    @(posedge hclk) disable iff (!hresetn)
    (line_chan_valid[0] && line_chan_num[4:0] == monsel_ff[0][4:0])
      |=> monval_ff[0] == $past(line_chan_data[7:0]);
  endproperty
  a_monitor: assert property (p_monitor) // R06
    else $error("monitor missed the selected channel");

  property p_slot;
    @(posedge hclk) disable iff (!hresetn)
    large_ctrl_slot_en[0] |-> $past(hit0 && xpc_ff[0][6] && !xpc_ff[0][7]);
  endproperty
  a_slot: assert property (p_slot) // R14
    else $error("controller slot enable without a pick");

  property p_crc;
    @(posedge hclk) disable iff (!hresetn)
    crc_multiframe_search[0] |-> $past(sync_ff[0][3] && sync_ff[0][2] && mode_ff[0][0]);
  endproperty
  a_crc: assert property (p_crc) // R16
    else $error("crc search without enable");

  property p_dir;
    @(posedge hclk) disable iff (!hresetn)
    !(test_port_to_rx[0] && test_port_to_tx[0]);
  endproperty
  a_dir: assert property (p_dir) // R10
    else $error("test port drives both paths");

  property p_rd_wait;
    @(posedge hclk) disable iff (!hresetn)
    (bus_st_ff == BUS_RD_WAIT) |-> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read wait state not exactly one cycle");

  c_write:   cover property (@(posedge hclk) disable iff (!hresetn) wr_en);
  c_read:    cover property (@(posedge hclk) disable iff (!hresetn)
                             bus_st_ff == BUS_RD_DONE && addr_ok);
  c_resync:  cover property (@(posedge hclk) disable iff (!hresetn) resync_start[0]);
  c_slot:    cover property (@(posedge hclk) disable iff (!hresetn) large_ctrl_slot_en[0]);

endmodule

// ---- bench/tpc_tx_path_regs_tb_top.sv ----
/* self-checking bench for the transmit path register bank: AHB-Lite
   singles per port, decoded settings, monitor capture and resync pulse.
   assumes hready loops back from hreadyout and hsize is always word. */
`timescale 1ns/1ps
module tpc_tx_path_regs_tb_top;
  import tpc_pkg::*;
  // ------------------------------------------------------------------
  // signals and tables
  // ------------------------------------------------------------------
  logic        hclk, hresetn, hsel, hwrite, hreadyout;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, q, dat, lbu, tbu;
  logic [3:0]  vld, ao, ci, slot, rsy, io, fr, la, lf, lsa, tt, tr, tf, se, cs, ar;
  logic [19:0] num, ll, ls, sau;
  logic [23:0] wm;
  int          error_cnt, n_checks;
  logic [8:0]  ix [13] = '{IDX_ALARM, IDX_WMARK, IDX_IBO, IDX_MONSEL, IDX_XPC, IDX_TPBS,
    IDX_MODE, IDX_LCBS, IDX_SYNC, IDX_CHS_A, IDX_CHS_B, IDX_CHS_C, IDX_CHS_D};
  logic [7:0]  mk [13] = '{MSK_ALARM, MSK_WMARK, MSK_IBO, MSK_MONSEL, MSK_XPC, MSK_FULL,
    MSK_MODE, MSK_FULL, MSK_SYNC, MSK_FULL, MSK_FULL, MSK_FULL, MSK_FULL};
  logic [4:0]  el [4] = '{LOOP_LONG_00, LOOP_LONG_01, LOOP_LONG_10, LOOP_LONG_11};
  logic [4:0]  es [4] = '{LOOP_LONG_00, LOOP_SHORT_01, LOOP_LONG_10, LOOP_SHORT_11};
  logic [5:0]  ew [4] = '{WMARK_00, WMARK_01, WMARK_10, WMARK_11};

  tpc_tx_path_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .line_chan_valid(vld),
    .line_chan_num(num), .line_chan_data(dat), .ais_all_ones(ao), .ais_ci_pattern(ci),
    .loop_len_long(ll), .loop_len_short(ls), .small_fifo_low_mark(wm),
    .interleave_on(io), .interleave_frame(fr), .large_ctrl_active(la), .large_ctrl_on_fdl(lf),
    .large_ctrl_on_sa(lsa), .large_ctrl_slot_en(slot), .large_ctrl_bit_use(lbu),
    .large_ctrl_sa_use(sau), .test_port_to_tx(tt), .test_port_to_rx(tr),
    .test_port_fbit_fill(tf), .test_port_bit_use(tbu), .sync_enable(se),
    .crc_multiframe_search(cs), .auto_resync_allowed(ar), .resync_start(rsy));

  // free-running bus clock, 50 ns
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // hang guard, far above the roughly 700 cycles the tests need
  initial begin
    repeat (5000) @(posedge hclk);
    error_cnt++;
    complete_run();
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one single transfer; hready sampled at negedge, it cannot change before the edge
  task automatic xfer(input logic wr, input logic [1:0] p, input logic [8:0] i,
                      input logic [7:0] d);
    logic r;
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {19'h0, p, i, 2'b00};
    do begin
      @(negedge hclk);
      r = hreadyout;
      @(posedge hclk);
    end while (r !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do begin
      @(negedge hclk);
      r = hreadyout;
      q = hrdata;
      @(posedge hclk);
    end while (r !== 1'b1);
  endtask
  // write the sync register and count resync pulses over the next cycles
  task automatic rs(input logic [7:0] d, input int e);
    int n;
    n = 0;
    xfer(1'b1, 2'd0, IDX_SYNC, d);
    repeat (4) begin
      @(negedge hclk);
      if (rsy[0] === 1'b1) n++;
    end
    chk(n, e);
  endtask
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    {hresetn, hsel, htrans, hwrite, haddr, hwdata, vld, num, dat} = '0;
    error_cnt = 0;
    n_checks = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    chk(wm[5:0], WMARK_00);
    // reset values, then distinct data per port with reserved bits set
    for (int p = 0; p < 4; p++)
      for (int k = 0; k < 13; k++) begin
        xfer(1'b0, 2'(p), ix[k], 8'h00);
        chk(q, 32'h0);
        xfer(1'b1, 2'(p), ix[k], 8'(255 - p));
      end
    for (int p = 0; p < 4; p++)
      for (int k = 0; k < 13; k++) begin
        xfer(1'b0, 2'(p), ix[k], 8'h00);
        chk(q, 32'((255 - p) & mk[k]));
      end
    // ports 0 and 2 sit in e1, ports 1 and 3 in t1, after the writes above
    chk(io, 4'hF);
    chk(fr, 4'hF);
    chk(la, 4'hF);
    chk(lf, 4'hA);
    chk(lsa, 4'h5);
    chk(tr, 4'h5);
    chk(tt, 4'h0);
    chk(tf, 4'h0);
    chk(tbu, 32'h03020100);
    chk(lbu, 32'h03020100);
    chk(sau, 20'hC2200);
    chk(se, 4'hF);
    chk(cs, 4'h5);
    chk(ar, 4'hC);
    xfer(1'b1, 2'd0, 9'h190, 8'hFF);
    xfer(1'b0, 2'd0, 9'h190, 8'h00);
    chk(q, 32'h0);
    $display("test registers done");
    rs(8'h0F, 0);
    rs(8'h0E, 0);
    rs(8'h0F, 1);
    for (int c = 0; c < 4; c++) begin
      xfer(1'b1, 2'd0, IDX_ALARM, 8'(c));
      xfer(1'b1, 2'd0, IDX_WMARK, 8'(c));
      repeat (2) @(negedge hclk);
      chk(ll[4:0], el[c]);
      chk(ls[4:0], es[c]);
      chk(wm[5:0], ew[c]);
    end
    // t1 with alarm send on: mode bit picks the pattern
    xfer(1'b1, 2'd0, IDX_MODE, 8'h02);
    xfer(1'b1, 2'd0, IDX_XPC, 8'h03);
    for (int m = 0; m < 2; m++) begin
      xfer(1'b1, 2'd0, IDX_ALARM, 8'(m * 4));
      repeat (2) @(negedge hclk);
      chk(ao[0], 1 - m);
      chk(ci[0], m);
    end
    chk({tt[0], tf[0], tr[0]}, 3'b110);
    $display("test decode done");
    // channel 32 picked and monitored; channel 31 neither
    xfer(1'b1, 2'd0, IDX_XPC, 8'h40);
    xfer(1'b1, 2'd0, IDX_CHS_D, 8'h80);
    for (int c = 0; c < 2; c++) begin
      @(posedge hclk);
      vld <= 4'h1;
      num <= 20'(31 - c);
      dat <= c ? 32'h5A : 32'hA5;
      @(posedge hclk);
      vld <= 4'h0;
      @(negedge hclk);
      chk(slot[0], 1 - c);
      xfer(1'b0, 2'd0, IDX_MONVAL, 8'h00);
      chk(q, 32'hA5);
    end
    $display("test channel done");
    complete_run();
  end
endmodule
